//--- design/line_io_pkg.sv
// Constants shared by the camera line I/O control block
package line_io_pkg;

	// ==========================================================
	// Geometry and timing
	localparam int LINES         = 4;
	localparam int ADDR_W        = 8;
	localparam int DATA_W        = 32;
	localparam int US_W          = 16;
	localparam int CNT_W         = 22;
	localparam int CLK_PERIOD_NS = 25;
	localparam int NS_PER_US     = 1000;
	localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_LINE_SEL  = 8'h00;
	localparam logic [7:0] OFF_LINE_DIR  = 8'h04;
	localparam logic [7:0] OFF_LINE_INV  = 8'h08;
	localparam logic [7:0] OFF_LINE_LVL  = 8'h0C;
	localparam logic [7:0] OFF_ALL_LVL   = 8'h10;
	localparam logic [7:0] OFF_FILT_SEL  = 8'h14;
	localparam logic [7:0] OFF_FILT_US   = 8'h18;
	localparam logic [7:0] OFF_LINE_SRC  = 8'h1C;
	localparam logic [7:0] OFF_SW_IDX    = 8'h20;
	localparam logic [7:0] OFF_SW_LVL    = 8'h24;
	localparam logic [7:0] OFF_SW_VEC    = 8'h28;
	localparam logic [7:0] OFF_CIRCUIT   = 8'h2C;

	// ==========================================================
	// Field encodings and reset values
	localparam logic       DIR_INPUT     = 1'b0;
	localparam logic       DIR_OUTPUT    = 1'b1;
	localparam logic       FILT_DEGLITCH = 1'b0;
	localparam logic       FILT_DEBOUNCE = 1'b1;
	localparam logic [1:0] CKT_TRISTATE  = 2'h0;
	localparam logic [1:0] CKT_OPTO      = 2'h1;
	localparam logic [1:0] CKT_OPEN_DRN  = 2'h2;
	localparam logic [3:0] SRC_LINE0     = 4'h0;
	localparam logic [3:0] SRC_USER0     = 4'h4;
	localparam logic [3:0] SRC_CNT0      = 4'h8;
	localparam logic [3:0] SRC_CNT1      = 4'h9;
	localparam logic [3:0] SRC_LB0       = 4'hA;
	localparam logic [3:0] SRC_LB1       = 4'hB;
	localparam logic [3:0] SRC_EXPOSURE  = 4'hC;
	localparam logic [3:0] SRC_TRIG_RDY  = 4'hD;
	localparam logic [3:0] SRC_RESET     = 4'h4;
	localparam logic [US_W-1:0] US_RESET = 16'h0000;

endpackage

//--- design/filter_stage.sv
// One input filter stage, deglitch or debounce by parameter
`timescale 1ns/1ps
module filter_stage
	import line_io_pkg::*;
#(
	parameter int CNT_BITS = CNT_W,
	parameter bit DEBOUNCE = 1'b0
) (
	input  wire logic                i_clk,
	input  wire logic                i_rst,
	input  wire logic                i_in,
	input  wire logic [CNT_BITS-1:0] i_cycles,
	output logic                     o_out
);

	// Counter must hold at least a count of three beside zero
	if (CNT_BITS < 2) begin : g_bad_width
		$error("filter counter needs at least two bits");
	end

	logic [CNT_BITS-1:0] cnt_q;
	logic                busy_q;
	logic                out_q;
	logic [CNT_BITS-1:0] cnt_inc;

	assign cnt_inc = cnt_q + {{(CNT_BITS-1){1'b0}}, 1'b1};
	assign o_out   = out_q;

	// ==========================================================
	// Filter state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			out_q  <= 1'b0;
			cnt_q  <= '0;
			busy_q <= 1'b0;
		end else if (!DEBOUNCE) begin
			// Any return to the accepted state restarts the wait
			if (i_in == out_q) begin
				cnt_q <= '0;
			end else if (cnt_inc >= i_cycles) begin
				out_q <= i_in;
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_inc;
			end
		end else begin
			if (busy_q) begin
				if (cnt_inc >= i_cycles) begin
					busy_q <= 1'b0;
					cnt_q  <= '0;
				end else begin
					cnt_q <= cnt_inc;
				end
			end else if (i_in != out_q) begin
				// First edge passes at once, then the lockout starts
				out_q  <= i_in;
				busy_q <= (i_cycles != '0);
				cnt_q  <= '0;
			end
		end
	end

	// ==========================================================
	// Checks
	glitch_wait_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(!DEBOUNCE && i_in != out_q && cnt_inc < i_cycles) |=> $stable(out_q))
		else $error("deglitch output moved before width expired");
	glitch_take_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(!DEBOUNCE && $changed(out_q)) |-> ($past(i_in) == out_q))
		else $error("deglitch output took a value not seen at input");
	bounce_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(DEBOUNCE && busy_q) |=> $stable(out_q))
		else $error("debounce output changed during lockout");
	bounce_pass_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(DEBOUNCE && !busy_q && i_in != out_q) |=> (out_q == $past(i_in)))
		else $error("debounce did not pass first edge at once");

endmodule

//--- design/camera_line_io_control.sv
// Four-line digital I/O control: direction, inversion, filters, sources
//
// Function
// - Four lines exist and a line index selects which one the per-line controls address.
// - Each line is set to input or output and is sampled or driven accordingly.
// - A per-line invert control flips the logic sense of the line.
// - The selected line's level reads 1 when high and 0 when low.
// - One read-only vector reports every line level with line zero at bit 0.
// - Each line keeps a deglitch and a debounce width in microseconds, picked by a filter choice.
// - Deglitch accepts a new state only after it has lasted the full width.
// - Debounce passes the first edge at once and then blocks changes for the width.
// - With both filters on, deglitch comes first and debounce second.
// - An output line is driven from a chosen source: another line, user bit, counter, logic block, exposure or trigger-ready.
// - The trigger-ready source is high exactly while a new frame start trigger can be taken.
// - A user output index picks one software bit whose written value sets it high or low.
// - A user output vector writes and reads all user bits at once, bit 0 for output zero.
// - A read-only per-line circuit type reports tri-state, opto-coupled or open-drain.
`timescale 1ns/1ps
module camera_line_io_control
	import line_io_pkg::*;
#(
	parameter int               NUM_LINES = LINES,
	parameter logic [2*LINES-1:0] CIRCUIT = {CKT_TRISTATE, CKT_OPEN_DRN, CKT_OPTO, CKT_OPTO}
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire logic [ADDR_W-1:0]    i_addr,
	input  wire logic [DATA_W-1:0]    i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic [DATA_W-1:0]         o_rdata,
	input  wire logic [NUM_LINES-1:0] i_line,
	output logic [NUM_LINES-1:0]      o_line,
	output logic [NUM_LINES-1:0]      o_line_oe_n,
	input  wire logic [1:0]           i_counter_active,
	input  wire logic [1:0]           i_logic_block,
	input  wire logic                 i_exposure_active,
	input  wire logic                 i_frame_trigger_ready
);

	// ==========================================================
	// Elaboration checks
	if (NUM_LINES != LINES) begin : g_bad_lines
		$error("source encoding serves exactly four lines");
	end

	// ==========================================================
	// Storage
	logic [1:0]                line_index_select_q;
	logic [NUM_LINES-1:0]      line_direction_q;
	logic [NUM_LINES-1:0]      line_polarity_invert_q;
	logic                      input_filter_choice_q;
	logic [US_W-1:0]           glitch_us_q [NUM_LINES];
	logic [US_W-1:0]           bounce_us_q [NUM_LINES];
	logic [3:0]                line_output_source_q [NUM_LINES];
	logic [1:0]                sw_output_index_q;
	logic [NUM_LINES-1:0]      sw_output_vector_q;
	logic [NUM_LINES-1:0]      all_lines_level_vector_q;
	logic [NUM_LINES-1:0]      raw_meta_q;
	logic [NUM_LINES-1:0]      raw_sync_q;
	logic [NUM_LINES-1:0]      deglitched;
	logic [NUM_LINES-1:0]      debounced;
	logic [NUM_LINES-1:0]      drive_d;
	logic [NUM_LINES-1:0]      level_d;
	logic [DATA_W-1:0]         rdata_d;
	logic [DATA_W-1:0]         rdata_q;
	logic [NUM_LINES-1:0]      line_q;
	logic [NUM_LINES-1:0]      oe_n_q;
	logic                      wr_sel;
	logic [1:0]                sel;

	assign sel    = line_index_select_q;
	assign wr_sel = i_wr;

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			raw_meta_q <= '0;
			raw_sync_q <= '0;
		end else begin
			raw_meta_q <= i_line;
			raw_sync_q <= raw_meta_q;
		end
	end

	// ==========================================================
	// Selector registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			line_index_select_q   <= 2'h0;
			input_filter_choice_q <= FILT_DEGLITCH;
			sw_output_index_q     <= 2'h0;
		end else if (wr_sel) begin
			if (i_addr == OFF_LINE_SEL) begin
				line_index_select_q <= i_wdata[1:0];
			end else if (i_addr == OFF_FILT_SEL) begin
				input_filter_choice_q <= i_wdata[0];
			end else if (i_addr == OFF_SW_IDX) begin
				sw_output_index_q <= i_wdata[1:0];
			end
		end
	end

	// ==========================================================
	// Per-line direction and inversion
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			line_direction_q       <= {NUM_LINES{DIR_INPUT}};
			line_polarity_invert_q <= '0;
		end else if (wr_sel) begin
			if (i_addr == OFF_LINE_DIR) begin
				line_direction_q[sel] <= i_wdata[0];
			end else if (i_addr == OFF_LINE_INV) begin
				line_polarity_invert_q[sel] <= i_wdata[0];
			end
		end
	end

	// ==========================================================
	// Per-line filter widths and output sources
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < NUM_LINES; i++) begin
				glitch_us_q[i]          <= US_RESET;
				bounce_us_q[i]          <= US_RESET;
				line_output_source_q[i] <= SRC_RESET;
			end
		end else if (wr_sel) begin
			if (i_addr == OFF_FILT_US) begin
				if (input_filter_choice_q == FILT_DEGLITCH) begin
					glitch_us_q[sel] <= i_wdata[US_W-1:0];
				end else begin
					bounce_us_q[sel] <= i_wdata[US_W-1:0];
				end
			end else if (i_addr == OFF_LINE_SRC) begin
				line_output_source_q[sel] <= i_wdata[3:0];
			end
		end
	end

	// ==========================================================
	// User outputs
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sw_output_vector_q <= '0;
		end else if (wr_sel) begin
			if (i_addr == OFF_SW_LVL) begin
				sw_output_vector_q[sw_output_index_q] <= i_wdata[0];
			end else if (i_addr == OFF_SW_VEC) begin
				sw_output_vector_q <= i_wdata[NUM_LINES-1:0];
			end
		end
	end

	// ==========================================================
	// Input filters, deglitch feeding debounce
	for (genvar g = 0; g < NUM_LINES; g++) begin : g_filt
		logic [CNT_W-1:0] glitch_cyc;
		logic [CNT_W-1:0] bounce_cyc;

		// A width of zero gives a count of zero, i.e. the stage only adds one clock of delay
		assign glitch_cyc = CNT_W'(glitch_us_q[g]) * CNT_W'(CYC_PER_US);
		assign bounce_cyc = CNT_W'(bounce_us_q[g]) * CNT_W'(CYC_PER_US);

		filter_stage #(
			.CNT_BITS (CNT_W),
			.DEBOUNCE (1'b0)
		) u_deglitch (
			.i_clk    (i_clk),
			.i_rst    (i_rst),
			.i_in     (raw_sync_q[g]),
			.i_cycles (glitch_cyc),
			.o_out    (deglitched[g])
		);

		filter_stage #(
			.CNT_BITS (CNT_W),
			.DEBOUNCE (1'b1)
		) u_debounce (
			.i_clk    (i_clk),
			.i_rst    (i_rst),
			.i_in     (deglitched[g]),
			.i_cycles (bounce_cyc),
			.o_out    (debounced[g])
		);
	end

	// ==========================================================
	// Output source selection
	function automatic logic pick_source(input logic [3:0] src,
	                                     input logic [NUM_LINES-1:0] lvl,
	                                     input logic [NUM_LINES-1:0] usr);
		logic v;
		v = 1'b0;
		case (src)
			SRC_LINE0, SRC_LINE0 + 4'h1, SRC_LINE0 + 4'h2, SRC_LINE0 + 4'h3: begin
				v = lvl[src[1:0]];
			end
			SRC_USER0, SRC_USER0 + 4'h1, SRC_USER0 + 4'h2, SRC_USER0 + 4'h3: begin
				v = usr[src[1:0]];
			end
			SRC_CNT0:     v = i_counter_active[0];
			SRC_CNT1:     v = i_counter_active[1];
			SRC_LB0:      v = i_logic_block[0];
			SRC_LB1:      v = i_logic_block[1];
			SRC_EXPOSURE: v = i_exposure_active;
			SRC_TRIG_RDY: v = i_frame_trigger_ready;
			default:      v = 1'b0;
		endcase
		return v;
	endfunction

	always_comb begin
		for (int i = 0; i < NUM_LINES; i++) begin
			// Loopback reads the registered level vector, so no combinational loop
			drive_d[i] = pick_source(line_output_source_q[i], all_lines_level_vector_q,
			                         sw_output_vector_q) ^ line_polarity_invert_q[i];
			if (line_direction_q[i] == DIR_OUTPUT) begin
				level_d[i] = drive_d[i];
			end else begin
				level_d[i] = debounced[i] ^ line_polarity_invert_q[i];
			end
		end
	end

	// ==========================================================
	// Pin drive and level capture
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			line_q                   <= '0;
			oe_n_q                   <= '1;
			all_lines_level_vector_q <= '0;
		end else begin
			line_q                   <= drive_d;
			all_lines_level_vector_q <= level_d;
			for (int i = 0; i < NUM_LINES; i++) begin
				// Open-drain lines only ever pull low; the high level is external
				if (CIRCUIT[2*i +: 2] == CKT_OPEN_DRN) begin
					oe_n_q[i] <= !(line_direction_q[i] && !drive_d[i]);
				end else begin
					oe_n_q[i] <= !line_direction_q[i];
				end
			end
		end
	end

	// ==========================================================
	// Read port
	always_comb begin
		rdata_d = '0;
		if (i_addr == OFF_LINE_SEL) begin
			rdata_d[1:0] = line_index_select_q;
		end else if (i_addr == OFF_LINE_DIR) begin
			rdata_d[0] = line_direction_q[sel];
		end else if (i_addr == OFF_LINE_INV) begin
			rdata_d[0] = line_polarity_invert_q[sel];
		end else if (i_addr == OFF_LINE_LVL) begin
			rdata_d[0] = all_lines_level_vector_q[sel];
		end else if (i_addr == OFF_ALL_LVL) begin
			rdata_d[NUM_LINES-1:0] = all_lines_level_vector_q;
		end else if (i_addr == OFF_FILT_SEL) begin
			rdata_d[0] = input_filter_choice_q;
		end else if (i_addr == OFF_FILT_US) begin
			rdata_d[US_W-1:0] = (input_filter_choice_q == FILT_DEGLITCH) ?
			                    glitch_us_q[sel] : bounce_us_q[sel];
		end else if (i_addr == OFF_LINE_SRC) begin
			rdata_d[3:0] = line_output_source_q[sel];
		end else if (i_addr == OFF_SW_IDX) begin
			rdata_d[1:0] = sw_output_index_q;
		end else if (i_addr == OFF_SW_LVL) begin
			rdata_d[0] = sw_output_vector_q[sw_output_index_q];
		end else if (i_addr == OFF_SW_VEC) begin
			rdata_d[NUM_LINES-1:0] = sw_output_vector_q;
		end else if (i_addr == OFF_CIRCUIT) begin
			rdata_d[1:0] = CIRCUIT[2*sel +: 2];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_q <= '0;
		end else if (i_rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= '0;
		end
	end

	assign o_rdata     = rdata_q;
	assign o_line      = line_q;
	assign o_line_oe_n = oe_n_q;

	// ==========================================================
	// Checks
	sequence vec_write_s;
		i_wr && i_addr == OFF_SW_VEC;
	endsequence

	sequence lvl_read_s;
		i_rd && i_addr == OFF_ALL_LVL;
	endsequence

	reset_state_a: assert property (@(posedge i_clk)
		i_rst |=> (line_direction_q == '0 && line_polarity_invert_q == '0 &&
		           sw_output_vector_q == '0 && oe_n_q == '1))
		else $error("reset state wrong");
	sw_vector_a: assert property (@(posedge i_clk) disable iff (i_rst)
		vec_write_s |=> (sw_output_vector_q == $past(i_wdata[NUM_LINES-1:0])))
		else $error("user vector write lost");
	sw_single_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_wr && i_addr == OFF_SW_LVL) |=>
		(sw_output_vector_q[$past(sw_output_index_q)] == $past(i_wdata[0])))
		else $error("user output bit write lost");
	level_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
		lvl_read_s |=> (o_rdata[NUM_LINES-1:0] == $past(all_lines_level_vector_q)))
		else $error("level vector read mismatch");
	input_no_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(line_direction_q == '0) |=> (o_line_oe_n == '1))
		else $error("input line driven");
	out_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(line_direction_q[1] && $stable(line_direction_q[1])) |=>
		(all_lines_level_vector_q[1] == o_line[1]))
		else $error("output line level readback wrong");
	trig_route_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(line_output_source_q[1] == SRC_TRIG_RDY && !line_polarity_invert_q[1]) |=>
		(o_line[1] == $past(i_frame_trigger_ready)))
		else $error("trigger ready not routed");
	read_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_rd |=> (o_rdata == '0))
		else $error("read data outside its cycle");

	// Open-drain lines may only sink; a high level comes from the pull-up
	for (genvar g = 0; g < NUM_LINES; g++) begin : g_od_chk
		if (CIRCUIT[2*g +: 2] == CKT_OPEN_DRN) begin : g_od
			od_sink_only_a: assert property (@(posedge i_clk) disable iff (i_rst)
				!o_line_oe_n[g] |-> !o_line[g])
				else $error("open-drain line driven high");
		end
	end

endmodule

//--- test/line_equipment_model.sv
// Behavioural model of the equipment wired to the four I/O lines
`timescale 1ns/1ps
module line_equipment_model
	import line_io_pkg::*;
#(
	parameter int OD_LINE = 2
) (
	input  wire logic [LINES-1:0] i_ext_level,
	input  wire logic [LINES-1:0] i_dev_line,
	input  wire logic [LINES-1:0] i_dev_oe_n,
	output logic      [LINES-1:0] o_pin
);
	// ==========================================================
	// Pin resolution
	always_comb begin
		for (int i = 0; i < LINES; i++) begin
			if (i == OD_LINE) begin
				// Wired-AND: the pull-up wins only while nobody sinks the line
				o_pin[i] = i_dev_oe_n[i] & i_ext_level[i];
			end else if (!i_dev_oe_n[i]) begin
				o_pin[i] = i_dev_line[i];
			end else begin
				// Equipment drives any line the device leaves alone
				o_pin[i] = i_ext_level[i];
			end
		end
	end
endmodule

//--- test/camera_line_io_control_tb_top.sv
// Self-checking testbench for the camera line I/O control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module camera_line_io_control_tb_top
	import line_io_pkg::*;
;
	// ==========================================================
	// Signals
	logic              clk;
	logic              rst;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr_s;
	logic              rd_s;
	logic [DATA_W-1:0] rdata;
	logic [LINES-1:0]  pin;
	logic [LINES-1:0]  ext;
	logic [LINES-1:0]  dev_line;
	logic [LINES-1:0]  dev_oe_n;
	logic [1:0]        cnt_act;
	logic [1:0]        lblk;
	logic              expo;
	logic              trig_rdy;
	int                n_errors;
	int                cmp_count;
	logic [1:0]        ckt [LINES] = '{CKT_OPTO, CKT_OPTO, CKT_OPEN_DRN, CKT_TRISTATE};

	// ==========================================================
	// Instances
	camera_line_io_control i_camera_line_io_control (
		.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
		.i_rd(rd_s), .o_rdata(rdata), .i_line(pin), .o_line(dev_line),
		.o_line_oe_n(dev_oe_n), .i_counter_active(cnt_act), .i_logic_block(lblk),
		.i_exposure_active(expo), .i_frame_trigger_ready(trig_rdy)
	);
	line_equipment_model i_line_equipment_model (
		.i_ext_level(ext), .i_dev_line(dev_line), .i_dev_oe_n(dev_oe_n), .o_pin(pin)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ==========================================================
	// Bus and helper tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		wr_s  <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex, input string nm);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		`CHK(nm, ex, rdata)
	endtask
	task automatic drive_src(input logic [3:0] c, input logic v);
		@(posedge clk);
		cnt_act  <= {c == SRC_CNT1 && v, c == SRC_CNT0 && v};
		lblk     <= {c == SRC_LB1 && v, c == SRC_LB0 && v};
		expo     <= c == SRC_EXPOSURE && v;
		trig_rdy <= c == SRC_TRIG_RDY && v;
	endtask
	task automatic conclude;
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		@(negedge clk);
		`CHK("oe_n", 4'hF, dev_oe_n)
		`CHK("line", 4'h0, dev_line)
		for (int i = 0; i < LINES; i++) begin
			wr(OFF_LINE_SEL, 32'(i));
			rchk(OFF_LINE_DIR, {31'h0, DIR_INPUT}, "dir");
			rchk(OFF_LINE_INV, 32'h0, "inv");
			rchk(OFF_FILT_US, 32'(US_RESET), "width");
			rchk(OFF_LINE_SRC, 32'(SRC_RESET), "src");
			rchk(OFF_CIRCUIT, 32'(ckt[i]), "circuit");
		end
		rchk(OFF_SW_VEC, 32'h0, "user vec");
		rchk(8'h3C, 32'h0, "unmapped");
	endtask

	task automatic t_inputs;
		@(posedge clk);
		ext <= 4'hA;
		cyc(10);
		rchk(OFF_ALL_LVL, 32'hA, "all levels");
		for (int i = 0; i < LINES; i++) begin
			wr(OFF_LINE_SEL, 32'(i));
			rchk(OFF_LINE_LVL, {31'h0, ext[i]}, "level");
		end
		wr(OFF_LINE_SEL, 32'h0);
		wr(OFF_LINE_INV, 32'h1);
		cyc(8);
		rchk(OFF_ALL_LVL, 32'hB, "inverted levels");
		wr(OFF_LINE_INV, 32'h0);
	endtask

	task automatic t_user;
		wr(OFF_SW_VEC, 32'h5);
		rchk(OFF_SW_VEC, 32'h5, "user vec");
		wr(OFF_SW_IDX, 32'h3);
		wr(OFF_SW_LVL, 32'h1);
		rchk(OFF_SW_VEC, 32'hD, "user vec");
		wr(OFF_SW_IDX, 32'h0);
		wr(OFF_SW_LVL, 32'h0);
		rchk(OFF_SW_VEC, 32'hC, "user vec");
		rchk(OFF_SW_LVL, 32'h0, "user level");
	endtask

	task automatic t_sources;
		logic [3:0] codes [6] = '{SRC_CNT0, SRC_CNT1, SRC_LB0, SRC_LB1, SRC_EXPOSURE,
			SRC_TRIG_RDY};
		wr(OFF_LINE_SEL, 32'h1);
		wr(OFF_LINE_DIR, 32'h1);
		wr(OFF_LINE_SRC, 32'(SRC_USER0) + 32'h3);
		cyc(3);
		@(negedge clk);
		`CHK("oe_n line1", 1'b0, dev_oe_n[1])
		`CHK("line1 user", 1'b1, dev_line[1])
		rchk(OFF_LINE_LVL, 32'h1, "out level");
		wr(OFF_LINE_INV, 32'h1);
		cyc(3);
		@(negedge clk);
		`CHK("line1 inv", 1'b0, dev_line[1])
		wr(OFF_LINE_INV, 32'h0);
		foreach (codes[k]) begin
			wr(OFF_LINE_SRC, 32'(codes[k]));
			for (int v = 1; v >= 0; v--) begin
				drive_src(codes[k], v[0]);
				cyc(3);
				@(negedge clk);
				`CHK("line1 src", v[0], dev_line[1])
			end
		end
		wr(OFF_LINE_SRC, 32'(SRC_LINE0));
		@(posedge clk);
		ext[0] <= 1'b1;
		cyc(10);
		@(negedge clk);
		`CHK("line1 loop", 1'b1, dev_line[1])
		@(posedge clk);
		ext[0] <= 1'b0;
		wr(OFF_LINE_DIR, 32'h0);
		cyc(3);
		@(negedge clk);
		`CHK("oe_n line1 in", 1'b1, dev_oe_n[1])
	endtask

	task automatic t_open_drain;
		wr(OFF_LINE_SEL, 32'h2);
		wr(OFF_LINE_DIR, 32'h1);
		cyc(3);
		@(negedge clk);
		`CHK("oe_n od low", 1'b0, dev_oe_n[2])
		wr(OFF_LINE_SRC, 32'(SRC_USER0) + 32'h3);
		cyc(3);
		@(negedge clk);
		`CHK("oe_n od high", 1'b1, dev_oe_n[2])
		wr(OFF_LINE_DIR, 32'h0);
	endtask

	task automatic t_deglitch;
		wr(OFF_LINE_SEL, 32'h0);
		wr(OFF_FILT_SEL, {31'h0, FILT_DEGLITCH});
		wr(OFF_FILT_US, 32'h1);
		@(posedge clk);
		ext[0] <= 1'b1;
		repeat (14) rchk(OFF_LINE_LVL, 32'h0, "deglitch");
		@(posedge clk);
		ext[0] <= 1'b0;
		cyc(2);
		ext[0] <= 1'b1;
		repeat (14) rchk(OFF_LINE_LVL, 32'h0, "deglitch restart");
		cyc(30);
		rchk(OFF_LINE_LVL, 32'h1, "deglitch accept");
	endtask

	task automatic t_debounce;
		wr(OFF_LINE_SEL, 32'h3);
		wr(OFF_FILT_SEL, {31'h0, FILT_DEBOUNCE});
		wr(OFF_FILT_US, 32'h1);
		cyc(10);
		@(posedge clk);
		ext[3] <= 1'b0;
		cyc(7);
		rchk(OFF_LINE_LVL, 32'h0, "debounce first");
		@(posedge clk);
		ext[3] <= 1'b1;
		repeat (8) rchk(OFF_LINE_LVL, 32'h0, "debounce lock");
		cyc(40);
		rchk(OFF_LINE_LVL, 32'h1, "debounce late");
		wr(OFF_FILT_SEL, {31'h0, FILT_DEGLITCH});
		wr(OFF_FILT_US, 32'h1);
		cyc(50);
		@(posedge clk);
		ext[3] <= 1'b0;
		repeat (12) rchk(OFF_LINE_LVL, 32'h1, "both held");
		cyc(30);
		rchk(OFF_LINE_LVL, 32'h0, "both accept");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		rst       = 1'b1;
		wr_s      = 1'b0;
		rd_s      = 1'b0;
		addr      = '0;
		wdata     = '0;
		ext       = '0;
		cnt_act   = '0;
		lblk      = '0;
		expo      = 1'b0;
		trig_rdy  = 1'b0;
		n_errors  = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_inputs;
		t_user;
		t_sources;
		t_open_drain;
		t_deglitch;
		t_debounce;
		conclude;
	end

	// Scenarios need well under 2000 cycles
	initial begin
		repeat (8000) @(posedge clk);
		n_errors++;
		conclude;
	end
endmodule
